// file: mrx_core.sv
// move/return instruction executor with an AXI4-Lite register slave
// assumes one clock, instruction words fed one at a time through the bus
// Function
// - bank literal goes into bank select
// - literal loads keep all status flags
// - seven-bit literal goes into pc high latch
// - eight-bit literal goes into working register
// - working register copied to addressed file register
// - two-bit field picks pre/post inc/dec
// - relative form adds signed offset, pointer kept
// - indirect write stores working, one of two pointers
// - indirect port redirects to pointer address
// - sixteen-bit pointers wrap both ways
// - pointer steps leave status flags alone
// - option load copies working, flags kept
// - software reset resets, clears reset flag
// - return pops stack into pc, two cycles
// - return sets global interrupt enable
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mrx_regs.svh"
module mrx_core (
  input wire logic clk,
  input wire logic rst,
  input wire mrx_pkg::mrx_axi_req_t axi_req,
  output var mrx_pkg::mrx_axi_rsp_t axi_rsp,
  output var logic global_irq_enable_o,
  output var logic soft_reset_pulse_o,
  output var logic [`MRX_PC_W-1:0] pc_o
);
  // core state
  mrx_pkg::mrx_state_t state_r, state_nxt;
  logic [`MRX_IW-1:0] instr_r, instr_nxt; // word under execution
  logic [7:0] work_r, work_nxt; // working register
  logic [4:0] bank_select_reg_r, bank_select_reg_nxt;
  logic [6:0] pc_high_latch_r, pc_high_latch_nxt;
  logic [7:0] option_r, option_nxt;
  logic [15:0] ptr_r [0:1]; // file select pointers
  logic [15:0] ptr_nxt [0:1];
  logic [`MRX_PC_W-1:0] pc_r, pc_nxt;
  logic [7:0] status_r, status_nxt; // flags, cleared by the software reset of this group and also writable over the bus
  logic [7:0] irq_control_reg_r, irq_control_reg_nxt;
  logic [7:0] power_control_reg_r, power_control_reg_nxt;
  logic [`MRX_MEM_AW-1:0] mem_addr_r, mem_addr_nxt; // peek address
  logic srst_r, srst_nxt; // soft reset pulse
  logic illegal_r, illegal_nxt; // last word was not of this group
  // bus state
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [`MRX_AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  mrx_pkg::mrx_axi_rsp_t rsp_r, rsp_nxt;
  // glue
  logic wr_fire, wr_err, rd_err, st_wr;
  logic [31:0] rd_data;
  logic exec, is_lb, is_lp, is_lw, is_wf, is_wi, is_wr, is_opt, is_sr, is_ret, is_idle;
  logic psel; // pointer index
  logic [15:0] cur, ea, ptr_new;
  logic mem_we;
  logic [`MRX_MEM_AW-1:0] mem_waddr;
  logic [7:0] mem_rdata;
  logic stk_push, stk_pop, stk_clr;
  logic [`MRX_PC_W-1:0] stk_top;
  logic [3:0] stk_level;

  // byte lane merge
  function automatic logic [7:0] m8(input logic [7:0] old, input logic [7:0] nw, input logic s);
    m8 = s ? nw : old;
  endfunction

  // decode of the word under execution
  always_comb begin
    exec = (state_r == mrx_pkg::MRX_ST_EXEC);
    is_lb = (instr_r[13:5] == `MRX_PFX_LB);
    is_lp = (instr_r[13:7] == `MRX_PFX_LP);
    is_lw = (instr_r[13:8] == `MRX_PFX_LW);
    is_wf = (instr_r[13:7] == `MRX_PFX_WF);
    is_wi = (instr_r[13:3] == `MRX_PFX_WI);
    is_wr = (instr_r[13:7] == `MRX_PFX_WR);
    is_opt = (instr_r == `MRX_OP_OPTION);
    is_sr = (instr_r == `MRX_OP_SRESET);
    is_ret = (instr_r == `MRX_OP_RETIRQ);
    is_idle = (instr_r == `MRX_OP_IDLE);
  end

  // effective address and pointer step
  always_comb begin
    psel = is_wr ? instr_r[6] : instr_r[2];
    cur = ptr_r[psel];
    ea = cur;
    ptr_new = cur;
    if (is_wr) begin
      ea = cur + {{10{instr_r[5]}}, instr_r[5:0]};
    end else begin
      case (instr_r[1:0])
        2'b00: begin
          ea = cur + 16'h0001;
          ptr_new = ea;
        end
        2'b01: begin
          ea = cur - 16'h0001;
          ptr_new = ea;
        end
        2'b10: ptr_new = cur + 16'h0001;
        2'b11: ptr_new = cur - 16'h0001;
        default: ptr_new = cur;
      endcase
    end
  end

  // memory write: direct, redirected, or indirect
  always_comb begin
    mem_we = exec && (is_wf || is_wi || is_wr);
    mem_waddr = {bank_select_reg_r, instr_r[6:0]};
    if (is_wi || is_wr) begin
      mem_waddr = ea[`MRX_MEM_AW-1:0];
    end else if (instr_r[6:1] == 6'h00) begin
      mem_waddr = ptr_r[instr_r[0]][`MRX_MEM_AW-1:0];
    end
  end

  // core next state: bus writes first, execution overrides
  always_comb begin
    state_nxt = state_r;
    instr_nxt = instr_r;
    work_nxt = work_r;
    bank_select_reg_nxt = bank_select_reg_r;
    pc_high_latch_nxt = pc_high_latch_r;
    option_nxt = option_r;
    ptr_nxt[0] = ptr_r[0];
    ptr_nxt[1] = ptr_r[1];
    pc_nxt = pc_r;
    status_nxt = status_r;
    irq_control_reg_nxt = irq_control_reg_r;
    power_control_reg_nxt = power_control_reg_r;
    mem_addr_nxt = mem_addr_r;
    illegal_nxt = illegal_r;
    srst_nxt = 1'b0;
    stk_push = 1'b0;
    stk_pop = 1'b0;
    stk_clr = 1'b0;
    wr_err = 1'b0;
    st_wr = wr_fire && (awaddr_r == `MRX_OFS_STATUS);
    if (wr_fire) begin
      case (awaddr_r)
        `MRX_OFS_INSTR: begin
          // a word is only taken while idle
          if (state_r == mrx_pkg::MRX_ST_IDLE) begin
            // unstrobed bytes keep the old word, 16-bit merge cut to 14 on purpose
            instr_nxt = 14'({m8({2'b00, instr_r[13:8]}, {2'b00, wdata_r[13:8]}, wstrb_r[1]),
                             m8(instr_r[7:0], wdata_r[7:0], wstrb_r[0])});
            state_nxt = mrx_pkg::MRX_ST_EXEC;
          end else begin
            wr_err = 1'b1;
          end
        end
        `MRX_OFS_WORK: work_nxt = m8(work_r, wdata_r[7:0], wstrb_r[0]);
        `MRX_OFS_PTR0: ptr_nxt[0] = {m8(ptr_r[0][15:8], wdata_r[15:8], wstrb_r[1]),
                                     m8(ptr_r[0][7:0], wdata_r[7:0], wstrb_r[0])};
        `MRX_OFS_PTR1: ptr_nxt[1] = {m8(ptr_r[1][15:8], wdata_r[15:8], wstrb_r[1]),
                                     m8(ptr_r[1][7:0], wdata_r[7:0], wstrb_r[0])};
        `MRX_OFS_STATUS: status_nxt = m8(status_r, wdata_r[7:0], wstrb_r[0]);
        `MRX_OFS_IRQCTL: irq_control_reg_nxt = m8(irq_control_reg_r, wdata_r[7:0], wstrb_r[0]);
        `MRX_OFS_PWRCTL: power_control_reg_nxt = m8(power_control_reg_r, wdata_r[7:0], wstrb_r[0]);
        `MRX_OFS_STACK: stk_push = wstrb_r[0];
        `MRX_OFS_MEMA: mem_addr_nxt = wdata_r[`MRX_MEM_AW-1:0];
        `MRX_OFS_BANK, `MRX_OFS_PCHI, `MRX_OFS_OPTION, `MRX_OFS_PC, `MRX_OFS_MEMD,
        `MRX_OFS_CORE: wr_err = 1'b0; // read-only, write ignored
        default: wr_err = 1'b1;
      endcase
    end
    case (state_r)
      mrx_pkg::MRX_ST_EXEC: begin
        state_nxt = mrx_pkg::MRX_ST_IDLE;
        pc_nxt = pc_r + 15'h0001;
        illegal_nxt = !(is_lb || is_lp || is_lw || is_wf || is_wi || is_wr || is_opt || is_idle);
        if (is_lb) begin
          bank_select_reg_nxt = instr_r[4:0];
        end
        if (is_lp) begin
          pc_high_latch_nxt = instr_r[6:0];
        end
        if (is_lw) begin
          work_nxt = instr_r[7:0];
        end
        if (is_wi) begin
          ptr_nxt[psel] = ptr_new;
        end
        if (is_opt) begin
          option_nxt = work_r;
        end
        if (is_ret) begin
          // pop into pc, re-enable interrupts, one more cycle follows
          pc_nxt = stk_top;
          stk_pop = 1'b1;
          irq_control_reg_nxt[`MRX_BIT_GLOBAL_IE] = 1'b1;
          state_nxt = mrx_pkg::MRX_ST_RET2;
          illegal_nxt = 1'b0;
        end
        if (is_sr) begin
          // core back to reset values except the word under execution and the power control bits besides the flag, which marks the cause
          work_nxt = 8'h00;
          bank_select_reg_nxt = 5'h00;
          pc_high_latch_nxt = 7'h00;
          option_nxt = `MRX_RST_OPTION;
          ptr_nxt[0] = 16'h0000;
          ptr_nxt[1] = 16'h0000;
          pc_nxt = '0;
          status_nxt = 8'h00;
          irq_control_reg_nxt = 8'h00;
          power_control_reg_nxt[`MRX_BIT_RI_N] = 1'b0;
          mem_addr_nxt = '0;
          stk_clr = 1'b1;
          srst_nxt = 1'b1;
          illegal_nxt = 1'b0;
        end
      end
      mrx_pkg::MRX_ST_RET2: state_nxt = mrx_pkg::MRX_ST_IDLE;
      default: state_nxt = state_nxt;
    endcase
  end

  // core registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= mrx_pkg::MRX_ST_IDLE;
      instr_r <= '0;
      work_r <= 8'h00;
      bank_select_reg_r <= 5'h00;
      pc_high_latch_r <= 7'h00;
      option_r <= `MRX_RST_OPTION;
      ptr_r[0] <= 16'h0000;
      ptr_r[1] <= 16'h0000;
      pc_r <= '0;
      status_r <= 8'h00;
      irq_control_reg_r <= 8'h00;
      power_control_reg_r <= `MRX_RST_PWRCTL;
      mem_addr_r <= '0;
      srst_r <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      instr_r <= instr_nxt;
      work_r <= work_nxt;
      bank_select_reg_r <= bank_select_reg_nxt;
      pc_high_latch_r <= pc_high_latch_nxt;
      option_r <= option_nxt;
      ptr_r[0] <= ptr_nxt[0];
      ptr_r[1] <= ptr_nxt[1];
      pc_r <= pc_nxt;
      status_r <= status_nxt;
      irq_control_reg_r <= irq_control_reg_nxt;
      power_control_reg_r <= power_control_reg_nxt;
      mem_addr_r <= mem_addr_nxt;
      srst_r <= srst_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // read mux for the address on the read channel
  always_comb begin
    rd_err = 1'b0;
    case (axi_req.araddr)
      `MRX_OFS_INSTR: rd_data = {18'h00000, instr_r};
      `MRX_OFS_WORK: rd_data = {24'h000000, work_r};
      `MRX_OFS_BANK: rd_data = {27'h0000000, bank_select_reg_r};
      `MRX_OFS_PCHI: rd_data = {25'h0000000, pc_high_latch_r};
      `MRX_OFS_OPTION: rd_data = {24'h000000, option_r};
      `MRX_OFS_PTR0: rd_data = {16'h0000, ptr_r[0]};
      `MRX_OFS_PTR1: rd_data = {16'h0000, ptr_r[1]};
      `MRX_OFS_PC: rd_data = {17'h00000, pc_r};
      `MRX_OFS_STATUS: rd_data = {24'h000000, status_r};
      `MRX_OFS_IRQCTL: rd_data = {24'h000000, irq_control_reg_r};
      `MRX_OFS_PWRCTL: rd_data = {24'h000000, power_control_reg_r};
      `MRX_OFS_STACK: rd_data = {13'h0000, stk_level, stk_top};
      `MRX_OFS_MEMA: rd_data = {20'h00000, mem_addr_r};
      `MRX_OFS_MEMD: rd_data = {24'h000000, mem_rdata};
      `MRX_OFS_CORE: rd_data = {27'h0000000, illegal_r, state_r, 1'b0};
      default: begin
        rd_data = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  // bus slave: address and data taken in any order, answer after both
  always_comb begin
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt = w_ok_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    rsp_nxt = rsp_r;
    wr_fire = aw_ok_r && w_ok_r && !rsp_r.bvalid;
    if (axi_req.awvalid && rsp_r.awready) begin
      aw_ok_nxt = 1'b1;
      awaddr_nxt = axi_req.awaddr;
    end
    if (axi_req.wvalid && rsp_r.wready) begin
      w_ok_nxt = 1'b1;
      wdata_nxt = axi_req.wdata;
      wstrb_nxt = axi_req.wstrb;
    end
    if (rsp_r.bvalid && axi_req.bready) begin
      rsp_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      rsp_nxt.bvalid = 1'b1;
      rsp_nxt.bresp = wr_err ? `MRX_RESP_SLVERR : `MRX_RESP_OKAY;
    end
    if (rsp_r.rvalid && axi_req.rready) begin
      rsp_nxt.rvalid = 1'b0;
    end
    if (axi_req.arvalid && rsp_r.arready) begin
      rsp_nxt.rvalid = 1'b1;
      rsp_nxt.rdata = rd_data;
      rsp_nxt.rresp = rd_err ? `MRX_RESP_SLVERR : `MRX_RESP_OKAY;
    end
    rsp_nxt.awready = !aw_ok_nxt && !rsp_nxt.bvalid;
    rsp_nxt.wready = !w_ok_nxt && !rsp_nxt.bvalid;
    rsp_nxt.arready = !rsp_nxt.rvalid;
  end

  // bus registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      rsp_r <= '0;
    end else begin
      aw_ok_r <= aw_ok_nxt;
      w_ok_r <= w_ok_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign axi_rsp = rsp_r;
  assign global_irq_enable_o = irq_control_reg_r[`MRX_BIT_GLOBAL_IE];
  assign soft_reset_pulse_o = srst_r;
  assign pc_o = pc_r;

  // file registers
  mrx_fmem u_fmem (
    .clk(clk),
    .rst(rst),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(work_r),
    .raddr(mem_addr_r),
    .rdata(mem_rdata)
  );

  // return stack
  mrx_stack u_stack (
    .clk(clk),
    .rst(rst),
    .clr(stk_clr),
    .push(stk_push),
    .push_data(wdata_r[`MRX_PC_W-1:0]),
    .pop(stk_pop),
    .top(stk_top),
    .level(stk_level)
  );

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ret_go;
    exec && is_ret;
  endsequence
  sequence s_ret_tail;
    (state_r == mrx_pkg::MRX_ST_RET2) ##1 (state_r == mrx_pkg::MRX_ST_IDLE);
  endsequence
  a_bank_load: assert property (exec && is_lb |=> bank_select_reg_r == $past(instr_r[4:0]))
    else $error("bank select not loaded");
  a_flags_keep: assert property (exec && (is_lb || is_lp || is_lw) && !st_wr |=> $stable(status_r))
    else $error("literal load changed flags");
  a_latch_load: assert property (exec && is_lp |=> pc_high_latch_r == $past(instr_r[6:0]))
    else $error("pc high latch not loaded");
  a_work_load: assert property (exec && is_lw |=> work_r == $past(instr_r[7:0]))
    else $error("working register not loaded");
  a_file_write: assert property (exec && is_wf && instr_r[6:1] != 6'h00 |-> mem_we && mem_waddr == {bank_select_reg_r, instr_r[6:0]})
    else $error("direct file write wrong");
  a_ptr_post: assert property (exec && is_wi && instr_r[1:0] == 2'b10 && !wr_fire |-> mem_waddr == cur[11:0] ##1 ptr_r[$past(psel)] == $past(cur) + 16'h0001)
    else $error("postincrement wrong");
  a_ptr_pre: assert property (exec && is_wi && instr_r[1:0] == 2'b01 && !wr_fire |-> mem_waddr == 12'(cur - 16'h0001) ##1 ptr_r[$past(psel)] == $past(cur) - 16'h0001)
    else $error("predecrement wrong");
  a_rel_hold: assert property (exec && is_wr && !wr_fire |=> ptr_r[$past(psel)] == $past(cur))
    else $error("relative form moved pointer");
  a_indir_data: assert property (exec && (is_wi || is_wr) |-> mem_we && mem_waddr == ea[11:0])
    else $error("indirect write not issued");
  a_port_redirect: assert property (exec && is_wf && instr_r[6:1] == 6'h00 |-> mem_waddr == ptr_r[instr_r[0]][11:0])
    else $error("indirect port not redirected");
  a_ptr_wrap: assert property (exec && is_wi && !instr_r[2] && instr_r[1:0] == 2'b00 && ptr_r[0] == 16'hffff && !wr_fire |=> ptr_r[0] == 16'h0000)
    else $error("pointer did not wrap");
  a_ptr_flags: assert property (exec && (is_wi || is_wr) && !st_wr |=> $stable(status_r))
    else $error("pointer step changed flags");
  a_option_load: assert property (exec && is_opt |=> option_r == $past(work_r) && $stable(status_r))
    else $error("option not loaded");
  a_soft_reset: assert property (exec && is_sr |=> soft_reset_pulse_o && !power_control_reg_r[`MRX_BIT_RI_N] && pc_r == '0 && work_r == 8'h00)
    else $error("software reset incomplete");
  a_ret_two: assert property (s_ret_go |=> s_ret_tail)
    else $error("return not two cycles");
  a_ret_pc: assert property (s_ret_go |=> pc_r == $past(stk_top) && global_irq_enable_o)
    else $error("return pc or enable wrong");
  a_idle_op: assert property (exec && is_idle && !wr_fire |=> pc_r == $past(pc_r) + 15'h0001 && $stable(work_r) && $stable(ptr_r[0]))
    else $error("idle op changed state");
endmodule
`default_nettype wire

// file: mrx_regs.svh
// register offsets, field positions, reset values and opcodes of the move/return core
// assumes byte addressing on a 32-bit AXI4-Lite bus, one aligned word per register
`ifndef MRX_REGS_SVH
`define MRX_REGS_SVH

// bus geometry
`define MRX_AW 8
// register byte offsets
`define MRX_OFS_INSTR 8'h00
`define MRX_OFS_WORK 8'h04
`define MRX_OFS_BANK 8'h08
`define MRX_OFS_PCHI 8'h0c
`define MRX_OFS_OPTION 8'h10
`define MRX_OFS_PTR0 8'h14
`define MRX_OFS_PTR1 8'h18
`define MRX_OFS_PC 8'h1c
`define MRX_OFS_STATUS 8'h20
`define MRX_OFS_IRQCTL 8'h24
`define MRX_OFS_PWRCTL 8'h28
`define MRX_OFS_STACK 8'h2c
`define MRX_OFS_MEMA 8'h30
`define MRX_OFS_MEMD 8'h34
`define MRX_OFS_CORE 8'h38
// widths
`define MRX_IW 14
`define MRX_PC_W 15
`define MRX_MEM_AW 12
`define MRX_MEM_DEPTH 4096
`define MRX_STK_DEPTH 16
// field positions
`define MRX_BIT_GLOBAL_IE 7
`define MRX_BIT_RI_N 0
// reset values
`define MRX_RST_OPTION 8'hff
`define MRX_RST_PWRCTL 8'h01
// bus responses
`define MRX_RESP_OKAY 2'b00
`define MRX_RESP_SLVERR 2'b10
// opcodes, full words
`define MRX_OP_IDLE 14'h0000
`define MRX_OP_SRESET 14'h0001
`define MRX_OP_RETIRQ 14'h0009
`define MRX_OP_OPTION 14'h0062
// opcode prefixes, compared against upper instruction bits
`define MRX_PFX_LB 9'h001
`define MRX_PFX_WF 7'h01
`define MRX_PFX_LW 6'h30
`define MRX_PFX_LP 7'h63
`define MRX_PFX_WI 11'h003
`define MRX_PFX_WR 7'h7f

`endif

// file: mrx_pkg.sv
// types shared by the move/return core: bus carriers and core states
// assumes mrx_regs.svh sits in the same folder
`include "mrx_regs.svh"
package mrx_pkg;
  // requests driven by the bus master
  typedef struct packed {
    logic awvalid;
    logic [`MRX_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`MRX_AW-1:0] araddr;
    logic rready;
  } mrx_axi_req_t;
  // answers driven by the core
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mrx_axi_rsp_t;
  // execution states, one-hot
  typedef enum logic [2:0] {
    MRX_ST_IDLE = 3'b001,
    MRX_ST_EXEC = 3'b010,
    MRX_ST_RET2 = 3'b100
  } mrx_state_t;
endpackage

// file: mrx_fmem.sv
// file register memory, one write port, one registered read port
// assumes one clock; contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
`include "mrx_regs.svh"
module mrx_fmem (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [`MRX_MEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [`MRX_MEM_AW-1:0] raddr,
  output var logic [7:0] rdata
);
  logic [7:0] mem [0:`MRX_MEM_DEPTH-1]; // storage array

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data leaves through a register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// file: mrx_stack.sv
// return address stack, circular, fixed depth
// assumes push and pop never come in the same cycle; pop wins if they do
`timescale 1ns/1ps
`default_nettype none
`include "mrx_regs.svh"
module mrx_stack (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic push,
  input wire logic [`MRX_PC_W-1:0] push_data,
  input wire logic pop,
  output var logic [`MRX_PC_W-1:0] top,
  output var logic [3:0] level
);
  logic [3:0] sp_r; // next free slot
  logic [3:0] sp_nxt;
  logic [`MRX_PC_W-1:0] ent_r [0:`MRX_STK_DEPTH-1]; // entries
  logic [`MRX_PC_W-1:0] ent_nxt [0:`MRX_STK_DEPTH-1];

  // pointer update, wraps around like the real thing
  always_comb begin
    sp_nxt = sp_r;
    if (clr) begin
      sp_nxt = 4'h0;
    end else if (pop) begin
      sp_nxt = sp_r - 4'h1;
    end else if (push) begin
      sp_nxt = sp_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_r <= 4'h0;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // one register per entry
  genvar i;
  generate
    for (i = 0; i < `MRX_STK_DEPTH; i++) begin : g_ent
      always_comb begin
        ent_nxt[i] = ent_r[i];
        if (push && !pop && !clr && sp_r == 4'(i)) begin
          ent_nxt[i] = push_data;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ent_r[i] <= '0;
        end else begin
          ent_r[i] <= ent_nxt[i];
        end
      end
    end
  endgenerate

  assign top = ent_r[sp_r - 4'h1];
  assign level = sp_r;
endmodule
`default_nettype wire

// file: test_move_return_instr_exec.sv
// self-checking bench for the move/return core, driven over its register bus
// assumes mrx_regs.svh and mrx_pkg are compiled first; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "mrx_regs.svh"
module test_move_return_instr_exec;
  logic clk; // 40 MHz bus and core clock
  logic rst; // async, active high
  mrx_pkg::mrx_axi_req_t req; // master requests
  mrx_pkg::mrx_axi_rsp_t rsp; // slave answers
  logic global_irq_enable; // global irq enable seen
  logic srst_pulse; // software reset pulse seen
  logic [`MRX_PC_W-1:0] pc; // program counter seen
  int error_cnt; // mismatches
  int n_tests; // comparisons made
  int pulse_cnt = 0; // software reset pulses counted, only the counter process writes it
  logic [31:0] rdat; // last read data
  logic [1:0] resp; // last bus response

  mrx_core uut (
    .clk(clk),
    .rst(rst),
    .axi_req(req),
    .axi_rsp(rsp),
    .global_irq_enable_o(global_irq_enable),
    .soft_reset_pulse_o(srst_pulse),
    .pc_o(pc)
  );

  // free running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // counts one-cycle reset pulses
  always @(posedge clk) begin
    if (srst_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
  end

  // compares one value, reports a mismatch
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // one read: rready held until the answer edge
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        rdat = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // reads a register and compares it
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
    rd(a);
    chk(name, exp, rdat);
  endtask

  // executes one word, leaves time for a two-cycle instruction
  task automatic ex(input logic [13:0] w);
    wr(`MRX_OFS_INSTR, {18'h0, w});
    repeat (2) @(posedge clk);
  endtask

  // peeks one memory byte
  task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp, input string name);
    wr(`MRX_OFS_MEMA, {20'h0, a});
    repeat (2) @(posedge clk);
    rdc(`MRX_OFS_MEMD, {24'h0, exp}, name);
  endtask

  task automatic t_literals;
    wr(`MRX_OFS_STATUS, 32'h5a);
    ex(14'h003f);
    ex(14'h31ff);
    ex(14'h30ff);
    rdc(`MRX_OFS_BANK, 32'h1f, "bank");
    rdc(`MRX_OFS_PCHI, 32'h7f, "pc_high");
    rdc(`MRX_OFS_WORK, 32'hff, "work");
    rdc(`MRX_OFS_STATUS, 32'h5a, "status");
  endtask

  task automatic t_move_file;
    ex(14'h0022);
    ex(14'h30a5);
    ex(14'h0090);
    mem_chk(12'h110, 8'ha5, "direct");
    wr(`MRX_OFS_PTR0, 32'h0345);
    ex(14'h303c);
    ex(14'h0080);
    mem_chk(12'h345, 8'h3c, "port");
    rdc(`MRX_OFS_STATUS, 32'h5a, "status");
  endtask

  // every pointer mode at the wrap boundary, both pointers
  task automatic t_indirect;
    logic [15:0] st [4] = '{16'hffff, 16'h0000, 16'hffff, 16'h0000};
    logic [11:0] ea [4] = '{12'h000, 12'hfff, 12'hfff, 12'h000};
    logic [15:0] pe [4] = '{16'h0000, 16'hffff, 16'h0000, 16'hffff};
    logic [7:0] pa;
    for (int m = 0; m < 4; m++) begin
      pa = (m % 2) ? `MRX_OFS_PTR1 : `MRX_OFS_PTR0;
      wr(pa, {16'h0, st[m]});
      ex(14'h3060 | 14'(m));
      ex(14'h0018 | 14'((m % 2) << 2) | 14'(m));
      mem_chk(ea[m], 8'h60 | 8'(m), "ind_data");
      rdc(pa, {16'h0, pe[m]}, "ind_ptr");
    end
    rdc(`MRX_OFS_STATUS, 32'h5a, "status");
  endtask

  task automatic t_relative;
    wr(`MRX_OFS_PTR1, 32'h0100);
    ex(14'h3077);
    ex(14'h3fe0);
    mem_chk(12'h0e0, 8'h77, "rel_low");
    ex(14'h3fdf);
    mem_chk(12'h11f, 8'h77, "rel_high");
    rdc(`MRX_OFS_PTR1, 32'h0100, "rel_ptr");
  endtask

  task automatic t_option;
    ex(14'h304f);
    ex(`MRX_OP_OPTION);
    rdc(`MRX_OFS_OPTION, 32'h4f, "option");
    rdc(`MRX_OFS_STATUS, 32'h5a, "status");
  endtask

  task automatic t_return;
    wr(`MRX_OFS_IRQCTL, 32'h0);
    wr(`MRX_OFS_STACK, 32'h1234);
    ex(`MRX_OP_RETIRQ);
    chk("pc_ret", 32'h1234, {17'h0, pc});
    chk("irq_enable", 32'h1, {31'h0, global_irq_enable});
    rdc(`MRX_OFS_IRQCTL, 32'h80, "irqctl");
    rd(`MRX_OFS_STACK);
    chk("stk_level", 32'h0, {28'h0, rdat[18:15]});
    ex(`MRX_OP_IDLE);
    chk("pc_idle", 32'h1235, {17'h0, pc});
    rdc(`MRX_OFS_WORK, 32'h4f, "work_idle");
  endtask

  task automatic t_sreset;
    int p0; // pulses counted before the word
    rdc(`MRX_OFS_PWRCTL, 32'h01, "pwr_rst");
    p0 = pulse_cnt;
    ex(`MRX_OP_SRESET);
    chk("pulses", 32'h1, pulse_cnt - p0);
    chk("pc_rst", 32'h0, {17'h0, pc});
    chk("irq_enable_rst", 32'h0, {31'h0, global_irq_enable});
    rdc(`MRX_OFS_PWRCTL, 32'h00, "pwr_flag");
    rdc(`MRX_OFS_OPTION, 32'hff, "opt_rst");
  endtask

  task automatic t_unmapped;
    wr(8'h3c, 32'h1);
    chk("wr_resp", `MRX_RESP_SLVERR, resp);
    rd(8'h3c);
    chk("rd_resp", `MRX_RESP_SLVERR, resp);
  endtask

  // prints the counts and the verdict, ends the run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    req = '0;
    rst = 1'b1;
    error_cnt = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(`MRX_OFS_OPTION, 32'hff, "opt_reset");
    t_literals();
    t_move_file();
    t_indirect();
    t_relative();
    t_option();
    t_return();
    t_sreset();
    t_unmapped();
    complete_run();
  end

  // hang guard, far beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
